//--- avmc_pkg.sv
package avmc_pkg;

    // ------------------------------------------------------------
    // serial slave address and control byte layout
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR   = 7'h76;
    localparam int         GAIN_MSB     = 7;
    localparam int         GAIN_LSB     = 3;
    localparam int         ENB_BIT      = 2;
    localparam int         ENA_BIT      = 1;
    localparam int         RW_BIT       = 0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [4:0] GAIN_RESET    = 5'h00;
    localparam logic       ENABLE_RESET  = 1'b0;
    localparam logic [7:0] GAIN_DB_RESET = 8'hBA;

    // ------------------------------------------------------------
    // timing: link clock is sampled, not used as a clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 50;
    localparam int LINK_MIN_PERIOD_NS = 2500;
    localparam int LINK_MIN_CYCLES    = LINK_MIN_PERIOD_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] gainCode;
        logic       enableB;
        logic       enableA;
    } avmc_ctrl_t;

    typedef enum logic [5:0] {
        ST_IDLE     = 6'h01,
        ST_ADDR     = 6'h02,
        ST_ADDR_ACK = 6'h04,
        ST_DATA     = 6'h08,
        ST_DATA_ACK = 6'h10,
        ST_IGNORE   = 6'h20
    } avmc_state_t;

endpackage : avmc_pkg

//--- avmc_gain_rom.sv
`timescale 1ns/1ns
module avmc_gain_rom (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic [4:0] gainCode,
    output logic      [7:0] gainDb
);

    // ------------------------------------------------------------
    // gain step table, signed dB, one word per code
    // ------------------------------------------------------------
    // entries copied verbatim; codes 10111 and 11000 are deliberately not monotonic
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            gainDb <= avmc_pkg::GAIN_DB_RESET;
        end else begin
            case (gainCode)
                5'h00: gainDb <= 8'hBA;
                5'h01: gainDb <= 8'hC8;
                5'h02: gainDb <= 8'hD2;
                5'h03: gainDb <= 8'hDA;
                5'h04: gainDb <= 8'hE0;
                5'h05: gainDb <= 8'hE4;
                5'h06: gainDb <= 8'hE8;
                5'h07: gainDb <= 8'hEB;
                5'h08: gainDb <= 8'hEE;
                5'h09: gainDb <= 8'hF1;
                5'h0A: gainDb <= 8'hF4;
                5'h0B: gainDb <= 8'hF6;
                5'h0C: gainDb <= 8'hF8;
                5'h0D: gainDb <= 8'hFA;
                5'h0E: gainDb <= 8'hFC;
                5'h0F: gainDb <= 8'hFE;
                5'h10: gainDb <= 8'h00;
                5'h11: gainDb <= 8'h02;
                5'h12: gainDb <= 8'h04;
                5'h13: gainDb <= 8'h06;
                5'h14: gainDb <= 8'h08;
                5'h15: gainDb <= 8'h0A;
                5'h16: gainDb <= 8'h0C;
                5'h17: gainDb <= 8'h10;
                5'h18: gainDb <= 8'h0E;
                5'h19: gainDb <= 8'h0F;
                5'h1A: gainDb <= 8'h10;
                5'h1B: gainDb <= 8'h11;
                5'h1C: gainDb <= 8'h12;
                5'h1D: gainDb <= 8'h16;
                5'h1E: gainDb <= 8'h17;
                default: gainDb <= 8'h18;
            endcase
        end
    end

endmodule : avmc_gain_rom

//--- avmc_volume_ctrl.sv
`timescale 1ns/1ns
module avmc_volume_ctrl (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       scl,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOeB,
    output logic [4:0]      gainCode,
    output logic            enableA,
    output logic            enableB,
    output logic            ampOn,
    output logic [7:0]      gainDb
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // pin order in the vectors: 1 is the clock line, 0 the data line
    logic [1:0] pinRaw;
    logic [1:0] pinS2;
    logic [1:0] pinS3;

    assign pinRaw = {scl, sdaIn};

    // idle bus level is high, so each chain resets high to avoid a false start
    for (genvar p = 0; p < 2; p++) begin : g_sync
        logic pinS1;

        always_ff @(posedge ref_clk) begin
            if (!rst_b) begin
                pinS1    <= 1'b1;
                pinS2[p] <= 1'b1;
                pinS3[p] <= 1'b1;
            end else begin
                pinS1    <= pinRaw[p];
                pinS2[p] <= pinS1;
                pinS3[p] <= pinS2[p];
            end
        end
    end

    logic sclS2;
    logic sclS3;
    logic sdaS2;
    logic sdaS3;

    assign sclS2 = pinS2[1];
    assign sclS3 = pinS3[1];
    assign sdaS2 = pinS2[0];
    assign sdaS3 = pinS3[0];

    // ------------------------------------------------------------
    // bus edges and frame conditions
    // ------------------------------------------------------------
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    assign sclRise   = sclS2 & ~sclS3;
    assign sclFall   = ~sclS2 & sclS3;
    assign startCond = sclS2 & sclS3 & sdaS3 & ~sdaS2;
    assign stopCond  = sclS2 & sclS3 & ~sdaS3 & sdaS2;

    // ------------------------------------------------------------
    // byte receiver state
    // ------------------------------------------------------------
    avmc_pkg::avmc_state_t state_q;
    logic [3:0]            bitCnt_q;
    logic [7:0]            shift_q;

    function automatic logic addrMatch(input logic [7:0] b);
        addrMatch = (b[7:1] == avmc_pkg::SLAVE_ADDR) && !b[avmc_pkg::RW_BIT];
    endfunction : addrMatch

    logic byteDone;
    assign byteDone = sclFall && (bitCnt_q == avmc_pkg::BITS_PER_BYTE);

    // reset holds the receiver idle, so nothing on the bus is seen
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_q  <= avmc_pkg::ST_IDLE;
            bitCnt_q <= 4'h0;
            shift_q  <= 8'h00;
        end else if (startCond) begin
            state_q  <= avmc_pkg::ST_ADDR;
            bitCnt_q <= 4'h0;
        end else if (stopCond) begin
            state_q  <= avmc_pkg::ST_IDLE;
            bitCnt_q <= 4'h0;
        end else begin
            case (state_q)
                avmc_pkg::ST_ADDR, avmc_pkg::ST_DATA: begin
                    if (sclRise) begin
                        shift_q  <= {shift_q[6:0], sdaS2};
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end else if (byteDone) begin
                        bitCnt_q <= 4'h0;
                        if (state_q == avmc_pkg::ST_DATA) begin
                            state_q <= avmc_pkg::ST_DATA_ACK;
                        end else if (addrMatch(shift_q)) begin
                            state_q <= avmc_pkg::ST_ADDR_ACK;
                        end else begin
                            state_q <= avmc_pkg::ST_IGNORE;
                        end
                    end
                end
                avmc_pkg::ST_ADDR_ACK: begin
                    if (sclFall) begin
                        state_q <= avmc_pkg::ST_DATA;
                    end
                end
                avmc_pkg::ST_DATA_ACK: begin
                    // one byte per frame; further bytes go unanswered
                    if (sclFall) begin
                        state_q <= avmc_pkg::ST_IGNORE;
                    end
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // byte decode
    // ------------------------------------------------------------
    logic addrAck;
    logic dataAck;

    // a read request or a foreign address leaves addrAck low, so no answer
    assign addrAck = byteDone && (state_q == avmc_pkg::ST_ADDR) && addrMatch(shift_q);
    assign dataAck = byteDone && (state_q == avmc_pkg::ST_DATA);

    // byte layout: gain code on top, enable B then enable A, bit 0 unused
    function automatic avmc_pkg::avmc_ctrl_t unpackCtrl(input logic [7:0] b);
        avmc_pkg::avmc_ctrl_t c;
        c.gainCode = b[avmc_pkg::GAIN_MSB:avmc_pkg::GAIN_LSB];
        c.enableB  = b[avmc_pkg::ENB_BIT];
        c.enableA  = b[avmc_pkg::ENA_BIT];
        return c;
    endfunction : unpackCtrl

    // ------------------------------------------------------------
    // acknowledge drive, open drain
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sdaOeB <= 1'b1;
        end else if (startCond || stopCond) begin
            sdaOeB <= 1'b1;
        end else if (addrAck) begin
            sdaOeB <= 1'b0;
        end else if (dataAck) begin
            sdaOeB <= 1'b0;
        end else if (sclFall) begin
            sdaOeB <= 1'b1;
        end
    end

    // line is only ever pulled low
    always_ff @(posedge ref_clk) begin
        sdaOut <= 1'b0;
    end

    // ------------------------------------------------------------
    // control byte
    // ------------------------------------------------------------
    avmc_pkg::avmc_ctrl_t ctrl_q;

    // only a full, acknowledged byte loads; shutdown bits never clear the gain
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ctrl_q.gainCode <= avmc_pkg::GAIN_RESET;
            ctrl_q.enableB  <= avmc_pkg::ENABLE_RESET;
            ctrl_q.enableA  <= avmc_pkg::ENABLE_RESET;
        end else if (dataAck) begin
            ctrl_q <= unpackCtrl(shift_q);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // gain output shares its latency with the table lookup below
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            gainCode <= avmc_pkg::GAIN_RESET;
        end else begin
            gainCode <= ctrl_q.gainCode;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            enableA <= avmc_pkg::ENABLE_RESET;
            enableB <= avmc_pkg::ENABLE_RESET;
            ampOn   <= 1'b0;
        end else begin
            enableA <= ctrl_q.enableA;
            enableB <= ctrl_q.enableB;
            // a single enable bit set is not a run state either
            ampOn   <= ctrl_q.enableA & ctrl_q.enableB;
        end
    end

    avmc_gain_rom u_gain_rom (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .gainCode (ctrl_q.gainCode),
        .gainDb   (gainDb)
    );

endmodule : avmc_volume_ctrl

//--- avmc_volume_ctrl_chk.sv
`timescale 1ns/1ns
module avmc_volume_ctrl_chk (
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       scl,
    input wire logic       sdaOeB,
    input wire logic [4:0] gainCode,
    input wire logic       enableA,
    input wire logic       enableB,
    input wire logic       ampOn,
    input wire logic [7:0] gainDb
);
    // table is non-monotonic on purpose, codes 10111 and 11000
    localparam logic [7:0] DB [32] = '{8'hBA, 8'hC8, 8'hD2, 8'hDA, 8'hE0, 8'hE4, 8'hE8, 8'hEB,
        8'hEE, 8'hF1, 8'hF4, 8'hF6, 8'hF8, 8'hFA, 8'hFC, 8'hFE, 8'h00, 8'h02, 8'h04, 8'h06,
        8'h08, 8'h0A, 8'h0C, 8'h10, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h16, 8'h17, 8'h18};
    AST_RST_VALUES: assert property (@(posedge ref_clk) !rst_b |=> gainCode == 5'h00
        && !enableA && !enableB && !ampOn && sdaOeB) else $error("reset values wrong");
    AST_RELEASE_SHUT: assert property (@(posedge ref_clk) $rose(rst_b) |=>
        !ampOn && gainDb == 8'hBA) else $error("not shut down after reset");
    AST_AMP_EQ: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ampOn == (enableA && enableB)) else $error("amp state differs from enables");
    AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $changed({gainCode, enableA, enableB}) |-> !sdaOeB) else $error("store without ack");
    AST_DB_TABLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        gainDb == DB[gainCode]) else $error("gain lookup wrong");
    AST_ACK_STANDS: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(sdaOeB) |=> (!sdaOeB) [*3]) else $error("ack too short");
    AST_ACK_START: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(sdaOeB) |-> !scl) else $error("ack began with clock high");
    AST_ACK_END: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(sdaOeB) |-> !scl) else $error("ack ended with clock high");
endmodule : avmc_volume_ctrl_chk

bind avmc_volume_ctrl avmc_volume_ctrl_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .scl(scl),
    .sdaOeB(sdaOeB), .gainCode(gainCode), .enableA(enableA), .enableB(enableB),
    .ampOn(ampOn), .gainDb(gainDb));

//--- avmc_host_model.sv
`timescale 1ns/1ns
module avmc_host_model (
    input  wire logic ref_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sdaRel
);
    initial begin
        scl = 1'b1;
        sdaRel = 1'b1;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : hw
    // data moves one cycle after clock falls, so no false start or stop
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sdaRel = b[i];
            hw(3);
            scl = 1'b1;
            hw(4);
            scl = 1'b0;
            hw(1);
        end
        sdaRel = 1'b1;
        hw(3);
        scl = 1'b1;
        hw(2);
        ack = ~sda;
        hw(2);
        scl = 1'b0;
        hw(1);
    endtask : send
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic a1, a2);
        a2 = 1'b0;
        sdaRel = 1'b0;
        hw(4);
        scl = 1'b0;
        hw(1);
        send(a, a1);
        if (a1) send(d, a2);
        sdaRel = 1'b0;
        hw(3);
        scl = 1'b1;
        hw(4);
        sdaRel = 1'b1;
        hw(4);
    endtask : xfer
endmodule : avmc_host_model

//--- amp_volume_mode_control_tb.sv
`timescale 1ns/1ns
module amp_volume_mode_control_tb;
    logic       ref_clk, rst_b, scl, sdaRel, sdaOut, sdaOeB, enableA, enableB, ampOn;
    logic [4:0] gainCode;
    logic [7:0] gainDb;
    logic       a1, a2;
    int         num_errors, total_checks;
    wire        sdaWire;
    // released line is pulled up
    assign sdaWire = sdaRel & (sdaOeB | sdaOut);
    avmc_volume_ctrl dut (.ref_clk(ref_clk), .rst_b(rst_b), .scl(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOeB(sdaOeB), .gainCode(gainCode), .enableA(enableA),
        .enableB(enableB), .ampOn(ampOn), .gainDb(gainDb));
    avmc_host_model m (.ref_clk(ref_clk), .sda(sdaWire), .scl(scl), .sdaRel(sdaRel));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [4:0] c, input logic [1:0] en);
        m.xfer(a, {c, en, 1'b0}, a1, a2);
    endtask : wr
    task automatic summarize;
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    task automatic t_all_codes;
        for (int c = 0; c < 32; c++) begin
            wr(8'hEC, c[4:0], 2'b11);
            chk({a1, a2}, 2'b11);
            chk(gainCode, c[4:0]);
            chk(ampOn, 1'b1);
            if (c == 23) chk(gainDb, 8'h10);
            if (c == 24) chk(gainDb, 8'h0E);
            if (c == 16) chk(gainDb, 8'h00);
        end
        chk(gainDb, 8'h18);
    endtask : t_all_codes
    task automatic t_shutdown;
        wr(8'hEC, 5'h12, 2'b00);
        chk({ampOn, enableA, enableB}, 3'b000);
        chk(gainCode, 5'h12);
        wr(8'hEC, 5'h12, 2'b01);
        chk({ampOn, enableA, enableB}, 3'b010);
        wr(8'hEC, 5'h12, 2'b10);
        chk({ampOn, enableA, enableB}, 3'b001);
        wr(8'hEC, 5'h12, 2'b11);
        chk({ampOn, gainCode}, {3'b001, 5'h12});
    endtask : t_shutdown
    task automatic t_refuse;
        wr(8'hEA, 5'h01, 2'b00);
        chk(a1, 1'b0);
        wr(8'hED, 5'h01, 2'b00);
        chk(a1, 1'b0);
        chk({ampOn, gainCode}, {3'b001, 5'h12});
    endtask : t_refuse
    task automatic t_reset;
        @(negedge ref_clk);
        rst_b = 1'b0;
        wr(8'hEC, 5'h1F, 2'b11);
        chk({a1, sdaOeB}, 2'b01);
        chk({ampOn, enableA, enableB, gainCode}, 8'h00);
        rst_b = 1'b1;
        m.hw(6);
        chk({ampOn, gainCode}, 8'h00);
        chk(gainDb, 8'hBA);
        chk(sdaOut, 1'b0);
        wr(8'hEC, 5'h05, 2'b11);
        chk({ampOn, gainCode}, {3'b001, 5'h05});
    endtask : t_reset
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        #2_000_000;
        num_errors++;
        summarize();
    end
    initial begin
        rst_b = 1'b0;
        num_errors = 0;
        total_checks = 0;
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        m.hw(6);
        t_all_codes();
        t_shutdown();
        t_refuse();
        t_reset();
        summarize();
    end
endmodule : amp_volume_mode_control_tb
